// ===== include/pep_params.svh
/*
 * Offsets, field positions and reset values of the port E pin control.
 * Assumes inclusion by bare name from the design.
 */
`ifndef PEP_PARAMS_SVH
`define PEP_PARAMS_SVH

// ----------------------------------------------------------------------
// Register word offsets (word addresses, one 32-bit word each).
// ----------------------------------------------------------------------
`define PEP_OFS_PIN_VALUE   4'h0
`define PEP_OFS_LATCH       4'h1
`define PEP_OFS_DIRECTION   4'h2
`define PEP_OFS_ANALOG      4'h3
`define PEP_OFS_INTERRUPT_CONTROL_TWO     4'h4
`define PEP_OFS_SLEW        4'h5
`define PEP_OFS_CONFIG      4'h6

// ----------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------
`define PEP_BIT_PULLUP_EN   7
`define PEP_BIT_GPU_DIS_N   7
`define PEP_BIT_PIN3        3
`define PEP_BIT_SLEW_E      4
`define PEP_BIT_CFG_MASTER_CLEAR_N    0
`define PEP_BIT_CFG_LVP     1
`define PEP_BIT_CFG_REMAP   2

// ----------------------------------------------------------------------
// Reset values and write masks.
// ----------------------------------------------------------------------
`define PEP_RST_DIRECTION   8'h07
`define PEP_RST_ANALOG      8'h07
`define PEP_RST_LATCH       8'h00
`define PEP_RST_INTERRUPT_CONTROL_TWO     8'h80
`define PEP_RST_SLEW        8'h1F
`define PEP_RST_CONFIG      8'h05
`define PEP_RST_PADS        4'h8
`define PEP_MSK_DIRECTION   8'h87
`define PEP_MSK_PINS        8'h07
`define PEP_MSK_INTERRUPT_CONTROL_TWO     8'hF5
`define PEP_MSK_SLEW        8'h1F
`define PEP_MSK_CONFIG      8'h07

`endif

// ===== include/pep_pkg.sv
/*
 * Types shared by the port E pin control files.
 * Assumes the parameter header is on the include path.
 */
package pep_pkg;

    // Peripheral outputs that may claim pins of the port.
    typedef struct packed {
        logic pwm3_a_en;    // Enhanced PWM 3 output A enable.
        logic pwm3_a;       // Enhanced PWM 3 output A level.
        logic pwm3_b_en;    // Enhanced PWM 3 output B enable.
        logic pwm3_b;       // Enhanced PWM 3 output B level.
        logic capcomp_unit3_io_en;      // Capture/compare 3 output enable.
        logic capcomp_unit3_io;         // Capture/compare 3 output level.
        logic capcomp_unit5_io_en;      // Capture/compare 5 output enable.
        logic capcomp_unit5_io;         // Capture/compare 5 output level.
    } pep_periph_t;

    // Per-pin driver decision.
    typedef struct packed {
        logic oe;           // Pin driver enabled.
        logic val;          // Level driven.
    } pep_drive_t;

endpackage : pep_pkg

// ===== hdl/pep_pin_mux.sv
/*
 * Output priority selection for one bidirectional pin.
 * Assumes enables and levels arrive on the system clock.
 */
module pep_pin_mux
    import pep_pkg::*;
(
    input  wire logic       i_hi_en,    // Highest priority output enable.
    input  wire logic       i_hi_val,   // Highest priority level.
    input  wire logic       i_lo_en,    // Second priority output enable.
    input  wire logic       i_lo_val,   // Second priority level.
    input  wire logic       i_dir,      // Direction bit, 0 is output.
    input  wire logic       i_lat,      // Output latch bit.
    output pep_drive_t      o_drive     // Resulting driver decision.
);

    // ------------------------------------------------------------------
    // Priority chain.
    // ------------------------------------------------------------------
    // Peripherals outrank the latch; analog select plays no part.
    assign o_drive.oe  = i_hi_en | i_lo_en | ~i_dir;
    assign o_drive.val = i_hi_en ? i_hi_val :
                         (i_lo_en ? i_lo_val : i_lat);

endmodule : pep_pin_mux

// ===== hdl/pep_port_e.sv
/*
 * Port E pin control: three bidirectional pins, one input-only pin that
 * doubles as master clear, pull-up, analog select and slew control.
 * Assumes an Avalon-MM master on I_MCLK and pads resolved outside.
 */
// The placing of the registers and the Avalon-MM register port were decided locally.
`include "pep_params.svh"

// Behaviour
// - Pin 3 pull-up follows its enable at direction bit 7, subject to global.
// - Pull-ups other than a forced pin 3 pull-up act only while the shared global disable bit is zero.
// - Global disable bit set switches every weak pull-up off except a forced pin 3 pull-up.
// - Power-on reset disables port B pull-ups; master clear select keeps pin 3 pull-up on.
// - Master clear or low-voltage programming forces pin 3 pull-up on.
// - Highest priority enabled peripheral output owns the pin driver.
// - Digital outputs may drive a pin in analog mode.
// - Direction 0 drives latch; 1 reads Schmitt; with analog, analog input.
// - Pin 0 carries PWM3 A and unit 3 when remap clear; pin 1 PWM3 B.
// - Pin 2 carries unit 5 output when output, capture input when input.
// - Master clear select 0 reads pin 3 at value bit 3.
// - Master clear select 1 with low-voltage programming off makes pin 3 an active-low reset.
// - Analog select disables digital input; reads return zero.
// - Analog select leaves the output path unaffected.
// - Reset sets all analog-select bits to one.
// - Reset sets direction bits 0 to 2 to one and pull-up enable bit 7 to zero.
// - Per-port slew select, reduced rate default after reset.
// - Value writes go to the latch; value reads return pin levels.
module pep_port_e
    import pep_pkg::*;
#(
    parameter int NPINS = 3                 // Bidirectional pin count.
)(
    input  wire logic        I_MCLK,         // System clock, 100 MHz.
    input  wire logic        I_RSTN,         // Async reset, active low.
    input  wire logic [3:0]  I_ADDRESS,      // Avalon word address.
    input  wire logic        I_READ,         // Avalon read.
    input  wire logic        I_WRITE,        // Avalon write.
    input  wire logic [3:0]  I_BYTEENABLE,   // Avalon byte enables.
    input  wire logic [31:0] I_WRITEDATA,    // Avalon write data.
    output logic      [31:0] O_READDATA,     // Avalon read data.
    output logic             O_WAITREQUEST,  // Avalon wait request.
    input  wire pep_periph_t I_PERIPH,       // Peripheral outputs.
    input  wire logic [2:0]  I_PIN_I,        // Pad levels pins 0 to 2.
    output logic      [2:0]  O_PIN_O,        // Pad drive levels.
    output logic      [2:0]  O_PIN_OE,       // Pad drive enables.
    output logic      [2:0]  O_ANALOG_EN,    // Analog input selects.
    input  wire logic        I_PIN3,         // Input-only pin level.
    output logic             O_PIN3_PULLUP,  // Weak pull-up on pin 3.
    output logic             O_PORTB_PU_GATE,// Port B pull-ups allowed.
    output logic             O_MASTER_CLEAR_N_RESET,   // Master clear reset asserted.
    output logic             O_CAPCOMP_UNIT3_IO_CAPTURE, // Capture 3 input.
    output logic             O_CAPCOMP_UNIT5_IO_CAPTURE, // Capture 5 input.
    output logic             O_SLEW_REDUCED  // Port E reduced slew.
);

    // Only the three-pin layout is implemented.
    if (NPINS != 3) begin : g_npins_check
        $error("pep_port_e serves exactly three bidirectional pins");
    end

    // ------------------------------------------------------------------
    // Reset release and input synchronisers.
    // ------------------------------------------------------------------
    logic       rst_s1_reg;
    logic       rst_n;
    logic [3:0] pin_s1_reg;
    logic [3:0] pin_s2_reg;

    // Reset asserts at once and releases after two clock edges.
    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            rst_s1_reg <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n      <= rst_s1_reg;
        end
    end

    // Pad levels pass two flip-flops before any logic sees them.
    // Pin 3 resets to its idle high level, so no false master clear.
    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_reg <= `PEP_RST_PADS;
            pin_s2_reg <= `PEP_RST_PADS;
        end else begin
            pin_s1_reg <= {I_PIN3, I_PIN_I};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // ------------------------------------------------------------------
    // Registers.
    // ------------------------------------------------------------------
    logic [7:0] port_e_output_latch_reg;
    logic [7:0] port_e_direction_reg;
    logic [7:0] port_e_analog_select_reg;
    logic [7:0] interrupt_control_two_reg;
    logic [7:0] slew_rate_select_reg;
    logic [7:0] config_reg;
    logic       ack_reg;

    // Byte-lane zero write strobe per register, at the answer edge only.
    function automatic logic wr_hit(input logic [3:0] ofs);
        wr_hit = I_WRITE && ack_reg && I_BYTEENABLE[0] && (I_ADDRESS == ofs);
    endfunction : wr_hit

    // Merge written bits under a writable mask.
    function automatic logic [7:0] merge(input logic [7:0] old,
                                         input logic [7:0] msk);
        merge = (old & ~msk) | (I_WRITEDATA[7:0] & msk);
    endfunction : merge

    wire wr_value  = wr_hit(`PEP_OFS_PIN_VALUE);
    wire wr_latch  = wr_hit(`PEP_OFS_LATCH);
    wire wr_dir    = wr_hit(`PEP_OFS_DIRECTION);
    wire wr_analog = wr_hit(`PEP_OFS_ANALOG);
    wire wr_intc   = wr_hit(`PEP_OFS_INTERRUPT_CONTROL_TWO);
    wire wr_slew   = wr_hit(`PEP_OFS_SLEW);
    wire wr_cfg    = wr_hit(`PEP_OFS_CONFIG);

    // Value register writes land in the latch.
    wire [7:0] latch_next = (wr_value | wr_latch) ?
        merge(port_e_output_latch_reg, `PEP_MSK_PINS) :
        port_e_output_latch_reg;
    wire [7:0] dir_next = wr_dir ?
        merge(port_e_direction_reg, `PEP_MSK_DIRECTION) :
        port_e_direction_reg;
    wire [7:0] analog_next = wr_analog ?
        merge(port_e_analog_select_reg, `PEP_MSK_PINS) :
        port_e_analog_select_reg;
    wire [7:0] intc_next = wr_intc ?
        merge(interrupt_control_two_reg, `PEP_MSK_INTERRUPT_CONTROL_TWO) :
        interrupt_control_two_reg;
    wire [7:0] slew_next = wr_slew ?
        merge(slew_rate_select_reg, `PEP_MSK_SLEW) :
        slew_rate_select_reg;
    wire [7:0] cfg_next = wr_cfg ?
        merge(config_reg, `PEP_MSK_CONFIG) : config_reg;

    // Register file; reset values set direction, analog and slew high.
    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n) begin
            port_e_output_latch_reg   <= `PEP_RST_LATCH;
            port_e_direction_reg      <= `PEP_RST_DIRECTION;
            port_e_analog_select_reg  <= `PEP_RST_ANALOG;
            interrupt_control_two_reg <= `PEP_RST_INTERRUPT_CONTROL_TWO;
            slew_rate_select_reg      <= `PEP_RST_SLEW;
            config_reg                <= `PEP_RST_CONFIG;
        end else begin
            port_e_output_latch_reg   <= latch_next;
            port_e_direction_reg      <= dir_next;
            port_e_analog_select_reg  <= analog_next;
            interrupt_control_two_reg <= intc_next;
            slew_rate_select_reg      <= slew_next;
            config_reg                <= cfg_next;
        end
    end

    // ------------------------------------------------------------------
    // Configuration and pull-up decode.
    // ------------------------------------------------------------------
    wire master_clear_select     = config_reg[`PEP_BIT_CFG_MASTER_CLEAR_N];
    wire low_voltage_prog_enable = config_reg[`PEP_BIT_CFG_LVP];
    wire capcomp3_pin_remap      = config_reg[`PEP_BIT_CFG_REMAP];
    wire global_pullup_disable_n =
        interrupt_control_two_reg[`PEP_BIT_GPU_DIS_N];
    wire pin3_pullup_enable = port_e_direction_reg[`PEP_BIT_PULLUP_EN];

    // Pin 3 acts as master clear when selected, unless low-voltage programming owns it.
    wire master_clear_n_mode = master_clear_select & ~low_voltage_prog_enable;
    wire pu_forced = master_clear_n_mode | low_voltage_prog_enable;
    wire pu_next   = pu_forced |
                     (pin3_pullup_enable & ~global_pullup_disable_n);

    // ------------------------------------------------------------------
    // Pin drivers.
    // ------------------------------------------------------------------
    wire [2:0]  dir = port_e_direction_reg[2:0];
    wire [2:0]  lat = port_e_output_latch_reg[2:0];
    wire        capcomp_unit3_io_here = ~capcomp3_pin_remap;
    pep_drive_t drv [3];

    // Pin 0: PWM3 A outranks compare 3; both only when mapped here.
    pep_pin_mux u_mux0 (
        .i_hi_en  (I_PERIPH.pwm3_a_en & capcomp_unit3_io_here),
        .i_hi_val (I_PERIPH.pwm3_a),
        .i_lo_en  (I_PERIPH.capcomp_unit3_io_en & capcomp_unit3_io_here),
        .i_lo_val (I_PERIPH.capcomp_unit3_io),
        .i_dir    (dir[0]),
        .i_lat    (lat[0]),
        .o_drive  (drv[0])
    );

    // Pin 1: PWM3 B over the latch.
    pep_pin_mux u_mux1 (
        .i_hi_en  (I_PERIPH.pwm3_b_en),
        .i_hi_val (I_PERIPH.pwm3_b),
        .i_lo_en  (1'b0),
        .i_lo_val (1'b0),
        .i_dir    (dir[1]),
        .i_lat    (lat[1]),
        .o_drive  (drv[1])
    );

    // Pin 2: compare 5 drives only while the pin is an output.
    pep_pin_mux u_mux2 (
        .i_hi_en  (I_PERIPH.capcomp_unit5_io_en & ~dir[2]),
        .i_hi_val (I_PERIPH.capcomp_unit5_io),
        .i_lo_en  (1'b0),
        .i_lo_val (1'b0),
        .i_dir    (dir[2]),
        .i_lat    (lat[2]),
        .o_drive  (drv[2])
    );

    wire [2:0] oe_next  = {drv[2].oe, drv[1].oe, drv[0].oe};
    wire [2:0] val_next = {drv[2].val, drv[1].val, drv[0].val};

    // ------------------------------------------------------------------
    // Input path.
    // ------------------------------------------------------------------
    // Analog-selected pins read zero; pin 3 reads only as a port pin.
    wire [2:0] din   = pin_s2_reg[2:0] &
                       ~port_e_analog_select_reg[2:0];
    wire       din3  = pin_s2_reg[3] & ~master_clear_select;
    wire [7:0] value_rd = {4'h0, din3, din};
    wire       master_clear_n_next = master_clear_n_mode & ~pin_s2_reg[3];
    wire       cap3_next = din[0] & dir[0] & capcomp_unit3_io_here;
    wire       cap5_next = din[2] & dir[2];

    // ------------------------------------------------------------------
    // Avalon read mux and answer.
    // ------------------------------------------------------------------
    wire  req = (I_READ | I_WRITE) & ~ack_reg;
    wire [7:0] rd_byte =
        (I_ADDRESS == `PEP_OFS_PIN_VALUE) ? value_rd :
        (I_ADDRESS == `PEP_OFS_LATCH)     ? port_e_output_latch_reg :
        (I_ADDRESS == `PEP_OFS_DIRECTION) ? port_e_direction_reg :
        (I_ADDRESS == `PEP_OFS_ANALOG)    ? port_e_analog_select_reg :
        (I_ADDRESS == `PEP_OFS_INTERRUPT_CONTROL_TWO)   ? interrupt_control_two_reg :
        (I_ADDRESS == `PEP_OFS_SLEW)      ? slew_rate_select_reg :
        (I_ADDRESS == `PEP_OFS_CONFIG)    ? config_reg : 8'h00;

    // Each request waits one cycle; the answer edge is the second one.
    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg       <= 1'b0;
            O_WAITREQUEST <= 1'b1;
            O_READDATA    <= 32'h0000_0000;
        end else begin
            ack_reg       <= req;
            O_WAITREQUEST <= ~req;
            O_READDATA    <= {24'h00_0000, rd_byte};
        end
    end

    // ------------------------------------------------------------------
    // Registered pin outputs.
    // ------------------------------------------------------------------
    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n) begin
            O_PIN_O         <= 3'h0;
            O_PIN_OE        <= 3'h0;
            O_ANALOG_EN     <= 3'h7;
            O_PIN3_PULLUP   <= 1'b0;
            O_PORTB_PU_GATE <= 1'b0;
            O_MASTER_CLEAR_N_RESET    <= 1'b0;
            O_CAPCOMP_UNIT3_IO_CAPTURE  <= 1'b0;
            O_CAPCOMP_UNIT5_IO_CAPTURE  <= 1'b0;
            O_SLEW_REDUCED  <= 1'b1;
        end else begin
            O_PIN_O         <= val_next;
            O_PIN_OE        <= oe_next;
            O_ANALOG_EN     <= port_e_analog_select_reg[2:0] & dir;
            O_PIN3_PULLUP   <= pu_next;
            O_PORTB_PU_GATE <= ~global_pullup_disable_n;
            O_MASTER_CLEAR_N_RESET    <= master_clear_n_next;
            O_CAPCOMP_UNIT3_IO_CAPTURE  <= cap3_next;
            O_CAPCOMP_UNIT5_IO_CAPTURE  <= cap5_next;
            O_SLEW_REDUCED  <= slew_rate_select_reg[`PEP_BIT_SLEW_E];
        end
    end

endmodule : pep_port_e

// ===== sim/pep_port_e_props.sv
/*
 * Checker for the port E pin control, bound to its top module.
 * Assumes one clock domain and the reset values of the design.
 */
module pep_port_e_props
    import pep_pkg::*;
(
    input wire logic        I_MCLK,         // System clock.
    input wire logic        I_RSTN,         // Reset, active low.
    input wire logic        I_READ,         // Bus read.
    input wire logic        I_WRITE,        // Bus write.
    input wire logic [31:0] O_READDATA,     // Bus read data.
    input wire logic        O_WAITREQUEST,  // Bus wait request.
    input wire pep_periph_t I_PERIPH,       // Peripheral outputs.
    input wire logic [2:0]  I_PIN_I,        // Pad levels.
    input wire logic [2:0]  O_PIN_O,        // Pad drive levels.
    input wire logic [2:0]  O_PIN_OE,       // Pad drive enables.
    input wire logic [2:0]  O_ANALOG_EN,    // Analog selects.
    input wire logic        O_PIN3_PULLUP,  // Pin 3 pull-up.
    input wire logic        O_PORTB_PU_GATE,// Global pull-up gate.
    input wire logic        O_CAPCOMP_UNIT3_IO_CAPTURE, // Capture 3 input.
    input wire logic        O_CAPCOMP_UNIT5_IO_CAPTURE, // Capture 5 input.
    input wire logic        O_SLEW_REDUCED  // Reduced slew.
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RSTN);

    // ------------------------------------------------------------------
    // Bus answer timing.
    // ------------------------------------------------------------------
    AST_WAIT_ONE: assert property (
        !O_WAITREQUEST |=> O_WAITREQUEST)
        else $error("wait request low longer than one cycle");
    AST_ANSWER: assert property ($rose(I_READ || I_WRITE) |->
        ##[1:3] !O_WAITREQUEST) else $error("bus answer late");
    AST_UPPER: assert property (!O_WAITREQUEST && I_READ |->
        O_READDATA[31:8] == 24'h0) else $error("upper data set");

    // ------------------------------------------------------------------
    // Reset values seen at the first edge after release.
    // ------------------------------------------------------------------
    AST_RST_PU: assert property ($rose(I_RSTN) |->
        !O_PIN3_PULLUP && !O_PORTB_PU_GATE) else $error("pull-up on");
    AST_RST_PIN: assert property ($rose(I_RSTN) |->
        O_ANALOG_EN == 3'h7 && O_PIN_OE == 3'h0) else $error("pin reset");
    AST_RST_SLEW: assert property ($rose(I_RSTN) |->
        O_SLEW_REDUCED) else $error("slew reset not reduced");

    // ------------------------------------------------------------------
    // Peripheral ownership and capture paths.
    // ------------------------------------------------------------------
    AST_PRIO_B: assert property (
        $past(I_PERIPH.pwm3_b_en) |->
        O_PIN_OE[1] && O_PIN_O[1] == $past(I_PERIPH.pwm3_b))
        else $error("pin 1 not owned by pwm output b");
    AST_CAP3: assert property (
        O_CAPCOMP_UNIT3_IO_CAPTURE |-> $past(I_PIN_I[0], 3))
        else $error("capture 3 without pad level");
    AST_CAP5: assert property (
        O_CAPCOMP_UNIT5_IO_CAPTURE |-> $past(I_PIN_I[2], 3))
        else $error("capture 5 without pad level");

    // Main scenarios reached.
    cover property ($fell(O_WAITREQUEST));
    cover property (O_PIN3_PULLUP && O_PORTB_PU_GATE);
    cover property (O_CAPCOMP_UNIT5_IO_CAPTURE && O_CAPCOMP_UNIT3_IO_CAPTURE);
endmodule : pep_port_e_props

bind pep_port_e pep_port_e_props i_pep_port_e_props (.I_MCLK, .I_RSTN,
    .I_READ, .I_WRITE, .O_READDATA, .O_WAITREQUEST, .I_PERIPH, .I_PIN_I,
    .O_PIN_O, .O_PIN_OE, .O_ANALOG_EN, .O_PIN3_PULLUP, .O_PORTB_PU_GATE,
    .O_CAPCOMP_UNIT3_IO_CAPTURE, .O_CAPCOMP_UNIT5_IO_CAPTURE, .O_SLEW_REDUCED);

// ===== sim/pep_board.sv
/*
 * Board circuitry at the port E pads.
 * Assumes the bench chooses external levels; floating pads toggle.
 */
module pep_board (
    input  wire logic       i_clk,      // Clock for the float pattern.
    input  wire logic [2:0] i_pin_o,    // Design drive levels.
    input  wire logic [2:0] i_pin_oe,   // Design drive enables.
    input  wire logic       i_pullup,   // Weak pull-up on pin 3.
    input  wire logic [2:0] i_ext,      // External levels.
    input  wire logic [2:0] i_ext_en,   // External drive enables.
    input  wire logic       i_ext3,     // External pin 3 level.
    input  wire logic       i_ext3_en,  // External pin 3 drive.
    output logic      [2:0] o_pin_i,    // Resolved pad levels.
    output logic            o_pin3      // Resolved pin 3 level.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic fl = 1'b0;

    // A floating pad shows a level that changes every cycle.
    always_ff @(posedge i_clk) begin
        fl <= ~fl;
    end

    // The design driver wins, then the board, else the pad floats.
    always_comb begin
        for (int k = 0; k < 3; k++) begin
            o_pin_i[k] = i_pin_oe[k] ? i_pin_o[k] :
                         (i_ext_en[k] ? i_ext[k] : fl);
        end
    end

    // Pin 3 floats low unless the weak pull-up holds it high.
    assign o_pin3 = i_ext3_en ? i_ext3 : i_pullup;
endmodule : pep_board

// ===== sim/pep_port_e_bench.sv
/*
 * Self-checking bench of the port E pin control.
 * Assumes the design answers each bus request within a few cycles.
 */
module pep_port_e_bench
    import pep_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] RST [8] = '{8'h00, 8'h00, 8'h07, 8'h07,
                                       8'h80, 8'h1F, 8'h05, 8'h00};
    localparam logic [7:0] MSK [8] = '{8'h00, 8'h07, 8'h87, 8'h07,
                                       8'hF5, 8'h1F, 8'h07, 8'h00};
    logic clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0, pu, gate;
    logic [3:0] addr = 4'h0, be = 4'hF;
    logic [31:0] wd = 32'h0, rdata;
    logic wait_req, master_clear_n, cap3, cap5, slew, pin3, ext3 = 1'b1, ext3_en = 1'b1;
    logic [2:0] pin_i, pin_o, pin_oe, ana, ext = 3'h0, ext_en = 3'h0;
    pep_periph_t periph = '0;
    int errors = 0, n_compared = 0;

    pep_port_e i_pep_port_e (.I_MCLK(clk), .I_RSTN(rstn), .I_ADDRESS(addr),
        .I_READ(rd), .I_WRITE(wr), .I_BYTEENABLE(be), .I_WRITEDATA(wd),
        .O_READDATA(rdata), .O_WAITREQUEST(wait_req), .I_PERIPH(periph),
        .I_PIN_I(pin_i), .O_PIN_O(pin_o), .O_PIN_OE(pin_oe),
        .O_ANALOG_EN(ana), .I_PIN3(pin3), .O_PIN3_PULLUP(pu),
        .O_PORTB_PU_GATE(gate), .O_MASTER_CLEAR_N_RESET(master_clear_n),
        .O_CAPCOMP_UNIT3_IO_CAPTURE(cap3), .O_CAPCOMP_UNIT5_IO_CAPTURE(cap5),
        .O_SLEW_REDUCED(slew));
    pep_board i_pep_board (.i_clk(clk), .i_pin_o(pin_o), .i_pin_oe(pin_oe),
        .i_pullup(pu), .i_ext(ext), .i_ext_en(ext_en), .i_ext3(ext3),
        .i_ext3_en(ext3_en), .o_pin_i(pin_i), .o_pin3(pin3));

    // The clock toggles every half period of 10 ns.
    always #5 clk = ~clk;

    // ------------------------------------------------------------------
    // Bus, compare and closing tasks.
    // ------------------------------------------------------------------
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        rd <= ~w;
        wr <= w;
        addr <= a;
        wd <= {24'h0, d};
        do begin
            @(posedge clk);
        end while (wait_req !== 1'b0);
        q = rdata[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask : chk8
    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask : wreg
    task automatic rchk(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        chk8(q, e);
    endtask : rchk
    task automatic settle;
        repeat (4) @(posedge clk);
    endtask : settle
    task automatic results;
        if (errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    // ------------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------------
    task automatic t_reset;
        chk8({5'h0, ana}, 8'h07);
        chk8({5'h0, pin_oe}, 8'h00);
        chk8({6'h0, gate, slew}, 8'h01);
        chk8({7'h0, pu}, 8'h01);
        chk8({7'h0, master_clear_n}, 8'h00);
        for (int i = 0; i < 8; i++) begin
            rchk(i[3:0], RST[i]);
        end
    endtask : t_reset
    task automatic t_masks;
        for (int i = 1; i < 8; i++) begin
            wreg(i[3:0], 8'hFF);
            rchk(i[3:0], MSK[i]);
        end
        be <= 4'h0;
        wreg(4'h1, 8'h00);
        be <= 4'hF;
        rchk(4'h1, 8'h07);
        wreg(4'h5, 8'h0F);
        settle;
        chk8({7'h0, slew}, 8'h00);
    endtask : t_masks
    task automatic t_pullup;
        wreg(4'h6, 8'h00);
        wreg(4'h4, 8'h80);
        wreg(4'h2, 8'h87);
        settle;
        chk8({6'h0, gate, pu}, 8'h00);
        wreg(4'h4, 8'h00);
        settle;
        chk8({6'h0, gate, pu}, 8'h03);
        ext3_en <= 1'b0;
        settle;
        rchk(4'h0, 8'h08);
        wreg(4'h2, 8'h07);
        settle;
        chk8({7'h0, pu}, 8'h00);
        rchk(4'h0, 8'h00);
        ext3_en <= 1'b1;
        wreg(4'h6, 8'h02);
        settle;
        chk8({7'h0, pu}, 8'h01);
        wreg(4'h6, 8'h01);
        wreg(4'h4, 8'h80);
        settle;
        chk8({7'h0, pu}, 8'h01);
    endtask : t_pullup
    task automatic t_pins;
        wreg(4'h6, 8'h00);
        wreg(4'h3, 8'h00);
        wreg(4'h2, 8'h00);
        wreg(4'h1, 8'h05);
        settle;
        chk8({2'h0, pin_oe, pin_o}, 8'h3D);
        rchk(4'h0, 8'h0D);
        wreg(4'h0, 8'h02);
        rchk(4'h1, 8'h02);
        wreg(4'h2, 8'h07);
        ext <= 3'h3;
        ext_en <= 3'h7;
        settle;
        rchk(4'h0, 8'h0B);
        wreg(4'h3, 8'h07);
        settle;
        rchk(4'h0, 8'h08);
        chk8({5'h0, ana}, 8'h07);
        wreg(4'h2, 8'h00);
        settle;
        chk8({2'h0, pin_oe, pin_o}, 8'h3A);
    endtask : t_pins
    task automatic t_periph;
        wreg(4'h2, 8'h07);
        periph <= '{pwm3_b_en: 1'b1, pwm3_b: 1'b1, pwm3_a_en: 1'b1,
                    capcomp_unit3_io_en: 1'b1, capcomp_unit3_io: 1'b1, default: 1'b0};
        settle;
        chk8({4'h0, pin_oe[1:0], pin_o[1:0]}, 8'h0E);
        periph.pwm3_a_en <= 1'b0;
        settle;
        chk8({7'h0, pin_o[0]}, 8'h01);
        periph <= '{capcomp_unit5_io_en: 1'b1, capcomp_unit5_io: 1'b1, default: 1'b0};
        wreg(4'h1, 8'h00);
        wreg(4'h2, 8'h03);
        settle;
        chk8({6'h0, pin_oe[2], pin_o[2]}, 8'h03);
        periph <= '0;
        wreg(4'h2, 8'h07);
        wreg(4'h3, 8'h00);
        ext <= 3'h5;
        settle;
        chk8({6'h0, cap5, cap3}, 8'h03);
    endtask : t_periph
    task automatic t_master_clear_n;
        wreg(4'h6, 8'h01);
        ext3 <= 1'b0;
        settle;
        chk8({7'h0, master_clear_n}, 8'h01);
        rchk(4'h0, 8'h05);
        ext3 <= 1'b1;
        settle;
        chk8({7'h0, master_clear_n}, 8'h00);
        wreg(4'h6, 8'h00);
        ext3 <= 1'b0;
        settle;
        chk8({7'h0, master_clear_n}, 8'h00);
        rchk(4'h0, 8'h05);
    endtask : t_master_clear_n

    // Reset for two cycles, then run every scenario.
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        t_reset;
        t_masks;
        t_pullup;
        t_pins;
        t_periph;
        t_master_clear_n;
        results;
    end

    // A hang ends the run as a failure.
    initial begin
        #100us;
        errors++;
        results;
    end
endmodule : pep_port_e_bench
